/* src/ser_status_report.sv */
// status word, fault latch, poll byte and error code reporting
`timescale 1ns/10ps

module ser_status_report #(
    parameter bit HAS_SPEED_MODES = 1'b1,
    parameter bit HAS_RELAY_OPTION = 1'b0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // analog conditions (asynchronous)
    input wire ser_pkg::ser_cond_type cond_in,
    // command events from the parser (same clock)
    input wire logic busy_in,
    input wire ser_pkg::ser_parse_err_type parse_err_in,
    input wire ser_pkg::ser_limit_err_type limit_err_in,
    input wire logic nv_save_fail_in,
    input wire logic pon_cmd_in,
    input wire logic pon_cmd_value_in,
    input wire logic relay_pon_cmd_in,
    input wire logic relay_cmd_in,
    input wire logic talk_addressed_in,
    input wire logic query_pending_in,
    input wire logic srq_cmd_in,
    input wire logic srq_cmd_value_in,
    input wire logic clear_command_in,
    input wire logic fault_mask_command_in,
    input wire logic [11:0] fault_mask_value_in,
    // register reads with side effects
    input wire logic err_query_in,
    input wire logic fault_query_in,
    input wire logic astatus_query_in,
    input wire logic serial_poll_in,
    // register contents
    output logic [11:0] operating_status_out,
    output logic [11:0] accumulated_status_out,
    output logic [11:0] fault_latch_out,
    output logic [11:0] fault_enable_mask_out,
    output logic [7:0] poll_summary_byte_out,
    // error reporting
    output logic [7:0] error_code_out,
    output logic error_valid_out,
    output logic [7:0] event_status_out
);

    // ************************************************************
    // condition synchronisers
    // ************************************************************
    localparam int COND_W = $bits(ser_pkg::ser_cond_type);
    logic [COND_W-1:0] cond_meta_reg;
    logic [COND_W-1:0] cond_sync_reg;
    ser_pkg::ser_cond_type cond_s;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cond_meta_reg <= '0;
            cond_sync_reg <= '0;
        end
        else
        begin
            cond_meta_reg <= cond_in;
            cond_sync_reg <= cond_meta_reg;
        end
    end
    assign cond_s = ser_pkg::ser_cond_type'(cond_sync_reg);

    // ************************************************************
    // error encoding
    // ************************************************************
    function automatic ser_pkg::ser_class_type err_class(input logic [7:0] code);
        // all compatibility codes are positive, so device-dependent
        err_class = ser_pkg::SER_CLS_DEV;
    endfunction

    logic [7:0] err_code_next;
    logic err_hit;
    logic pon_seen_reg;
    logic pon_second;

    assign pon_second = pon_cmd_in && pon_seen_reg;

    always_comb
    begin
        err_code_next = ser_pkg::ERR_NONE;
        // lowest priority first so the parser's fault wins a tie
        if (nv_save_fail_in)
            err_code_next = ser_pkg::ERR_NV_SAVE;
        if (pon_second)
            err_code_next = ser_pkg::ERR_SECOND_PON;
        if (relay_cmd_in && !HAS_RELAY_OPTION)
            err_code_next = ser_pkg::ERR_RELAY;
        if (relay_pon_cmd_in && !HAS_RELAY_OPTION)
            err_code_next = ser_pkg::ERR_RELAY_PON;
        if (talk_addressed_in && !query_pending_in)
            err_code_next = ser_pkg::ERR_TALK_NO_QUERY;
        if (limit_err_in.mask) err_code_next = ser_pkg::ERR_MASK_LIMIT;
        if (limit_err_in.delay) err_code_next = ser_pkg::ERR_DELAY_LIMIT;
        if (limit_err_in.ovp) err_code_next = ser_pkg::ERR_OVP_LIMIT;
        if (limit_err_in.curr) err_code_next = ser_pkg::ERR_CURR_LIMIT;
        if (limit_err_in.volt) err_code_next = ser_pkg::ERR_VOLT_LIMIT;
        if (limit_err_in.generic) err_code_next = ser_pkg::ERR_LIMIT;
        if (parse_err_in.missing_term) err_code_next = ser_pkg::ERR_TERMINATOR;
        if (parse_err_in.missing_comma) err_code_next = ser_pkg::ERR_COMMA;
        if (parse_err_in.num_range) err_code_next = ser_pkg::ERR_NUM_RANGE;
        if (parse_err_in.num_syntax) err_code_next = ser_pkg::ERR_NUM_SYNTAX;
        if (parse_err_in.num_expected) err_code_next = ser_pkg::ERR_NUM_EXPECTED;
        if (parse_err_in.hdr_unknown) err_code_next = ser_pkg::ERR_HDR_UNKNOWN;
        if (parse_err_in.hdr_expected) err_code_next = ser_pkg::ERR_HDR_EXPECTED;
    end
    assign err_hit = (err_code_next != ser_pkg::ERR_NONE);

    // ************************************************************
    // error code register and event status
    // ************************************************************
    logic [7:0] error_code_reg;
    logic [7:0] event_status_reg;
    ser_pkg::ser_class_type cls;

    assign cls = err_class(err_code_next);

    // code stays until read; a new error in the read cycle wins
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            error_code_reg <= ser_pkg::ERR_NONE;
        else if (err_hit)
            error_code_reg <= err_code_next;
        else if (err_query_in)
            error_code_reg <= ser_pkg::ERR_NONE;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            event_status_reg <= '0;
        else if (err_hit)
        begin
            // set wins a tie with the clear: the new class bit survives
            if (clear_command_in)
                event_status_reg <= '0;
            case (cls)
                ser_pkg::SER_CLS_CMD: event_status_reg[ser_pkg::ESR_CMD] <= 1'b1;
                ser_pkg::SER_CLS_EXEC: event_status_reg[ser_pkg::ESR_EXEC] <= 1'b1;
                ser_pkg::SER_CLS_DEV: event_status_reg[ser_pkg::ESR_DEVICE] <= 1'b1;
                ser_pkg::SER_CLS_QUERY: event_status_reg[ser_pkg::ESR_QUERY] <= 1'b1;
                default: ;
            endcase
        end
        else if (clear_command_in)
            event_status_reg <= '0;
    end

    // ************************************************************
    // programming error and power-on service tracking
    // ************************************************************
    logic prog_err_reg;
    logic prog_err_next;
    logic srq_enable_reg;

    // next value feeds the status word so bit 7 and the poll copy move together
    always_comb
    begin
        prog_err_next = prog_err_reg;
        if (err_hit)
            prog_err_next = 1'b1;
        else if (err_query_in)
            prog_err_next = 1'b0;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            prog_err_reg <= 1'b0;
        else
            prog_err_reg <= prog_err_next;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            pon_seen_reg <= 1'b0;
        else if (pon_cmd_in)
            pon_seen_reg <= 1'b1;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            srq_enable_reg <= 1'b0;
        else if (srq_cmd_in)
            srq_enable_reg <= srq_cmd_value_in;
    end

    // ************************************************************
    // operating status word
    // ************************************************************
    logic [11:0] status_now;

    always_comb
    begin
        status_now = '0;
        status_now[ser_pkg::BIT_VOLT_REG] = cond_s.volt_regulating;
        status_now[ser_pkg::BIT_POS_CURR] = cond_s.pos_current_regulating;
        status_now[ser_pkg::BIT_UNREG] = !cond_s.volt_regulating
            && !cond_s.pos_current_regulating
            && !cond_s.neg_current_regulating;
        status_now[ser_pkg::BIT_OVP] = cond_s.overvoltage_trip;
        status_now[ser_pkg::BIT_OTP] = cond_s.overtemp_trip;
        status_now[ser_pkg::BIT_UNUSED] = 1'b0;
        status_now[ser_pkg::BIT_OCP] = cond_s.overcurrent_trip;
        status_now[ser_pkg::BIT_PROG_ERR] = prog_err_next;
        status_now[ser_pkg::BIT_INHIBIT] = cond_s.remote_inhibit_flag;
        status_now[ser_pkg::BIT_NEG_CURR] = cond_s.neg_current_regulating;
        status_now[ser_pkg::BIT_FAST] = HAS_SPEED_MODES && cond_s.fast_speed_flag;
        status_now[ser_pkg::BIT_NORMAL] = HAS_SPEED_MODES && cond_s.normal_speed_flag;
    end

    // ************************************************************
    // accumulated status, mask and fault latch
    // ************************************************************
    logic [11:0] astatus_reg;
    logic [11:0] mask_reg;
    logic [11:0] fault_reg;

    // same bit index means the same condition in all four words
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            astatus_reg <= ser_pkg::STAT_RESET;
        else if (astatus_query_in)
            astatus_reg <= status_now;
        else
            astatus_reg <= astatus_reg | status_now;
    end

    // mask arrives as a decoded bit-weight sum; bit 5 is never kept
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            mask_reg <= ser_pkg::MASK_RESET;
        else if (fault_mask_command_in && !limit_err_in.mask)
            mask_reg <= fault_mask_value_in & ser_pkg::STAT_VALID_MASK;
    end

    // set beats the query clear so no fault edge is lost
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            fault_reg <= ser_pkg::STAT_RESET;
        else if (fault_query_in)
            fault_reg <= status_now & mask_reg;
        else
            fault_reg <= fault_reg | (status_now & mask_reg);
    end

    // ************************************************************
    // poll summary byte
    // ************************************************************
    logic powerup_flag_reg;
    logic ready_flag_reg;
    logic service_request_flag_reg;
    logic fault_summary_flag;
    logic fault_summary_prev_reg;

    assign fault_summary_flag = |fault_reg;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            powerup_flag_reg <= 1'b1;
        else if (clear_command_in)
            powerup_flag_reg <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            ready_flag_reg <= 1'b1;
        else
            ready_flag_reg <= !busy_in;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            fault_summary_prev_reg <= 1'b0;
        else
            fault_summary_prev_reg <= fault_summary_flag;
    end

    // a new request in the poll cycle survives the poll
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            service_request_flag_reg <= 1'b0;
        else if (fault_summary_flag && !fault_summary_prev_reg && srq_enable_reg)
            service_request_flag_reg <= 1'b1;
        else if (serial_poll_in)
            service_request_flag_reg <= 1'b0;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            operating_status_out <= ser_pkg::STAT_RESET;
        else
            operating_status_out <= status_now;
    end

    always_comb
    begin
        poll_summary_byte_out = '0;
        poll_summary_byte_out[ser_pkg::PBIT_FAULT] = fault_summary_flag;
        poll_summary_byte_out[ser_pkg::PBIT_POWERUP] = powerup_flag_reg;
        poll_summary_byte_out[ser_pkg::PBIT_READY] = ready_flag_reg;
        poll_summary_byte_out[ser_pkg::PBIT_ERR] = prog_err_reg;
        poll_summary_byte_out[ser_pkg::PBIT_SRQ] = service_request_flag_reg;
    end

    assign accumulated_status_out = astatus_reg;
    assign fault_latch_out = fault_reg;
    assign fault_enable_mask_out = mask_reg;
    assign error_code_out = error_code_reg;
    assign error_valid_out = prog_err_reg;
    assign event_status_out = event_status_reg;

endmodule

/* src/ser_pkg.sv */
// package for the status and error reporting block: layouts, codes, reset values
package ser_pkg;

    // ************************************************************
    // operating status word layout (shared by all four registers)
    // ************************************************************
    localparam int STAT_W = 12;
    localparam int BIT_VOLT_REG = 0;
    localparam int BIT_POS_CURR = 1;
    localparam int BIT_UNREG = 2;
    localparam int BIT_OVP = 3;
    localparam int BIT_OTP = 4;
    localparam int BIT_UNUSED = 5;
    localparam int BIT_OCP = 6;
    localparam int BIT_PROG_ERR = 7;
    localparam int BIT_INHIBIT = 8;
    localparam int BIT_NEG_CURR = 9;
    localparam int BIT_FAST = 10;
    localparam int BIT_NORMAL = 11;
    localparam logic [11:0] STAT_RESET = 12'h000;
    localparam logic [11:0] MASK_RESET = 12'h000;
    localparam logic [11:0] STAT_VALID_MASK = 12'hfdf;

    // ************************************************************
    // poll summary byte layout
    // ************************************************************
    localparam int POLL_W = 8;
    localparam int PBIT_FAULT = 0;
    localparam int PBIT_POWERUP = 1;
    localparam int PBIT_READY = 4;
    localparam int PBIT_ERR = 5;
    localparam int PBIT_SRQ = 6;

    // ************************************************************
    // error codes
    // ************************************************************
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_NV_SAVE = 8'h01;
    localparam logic [7:0] ERR_SECOND_PON = 8'h02;
    localparam logic [7:0] ERR_RELAY_PON = 8'h04;
    localparam logic [7:0] ERR_RELAY = 8'h05;
    localparam logic [7:0] ERR_TALK_NO_QUERY = 8'h08;
    localparam logic [7:0] ERR_HDR_EXPECTED = 8'h0a;
    localparam logic [7:0] ERR_HDR_UNKNOWN = 8'h0b;
    localparam logic [7:0] ERR_NUM_EXPECTED = 8'h14;
    localparam logic [7:0] ERR_NUM_SYNTAX = 8'h15;
    localparam logic [7:0] ERR_NUM_RANGE = 8'h16;
    localparam logic [7:0] ERR_COMMA = 8'h1e;
    localparam logic [7:0] ERR_TERMINATOR = 8'h1f;
    localparam logic [7:0] ERR_LIMIT = 8'h29;
    localparam logic [7:0] ERR_VOLT_LIMIT = 8'h2a;
    localparam logic [7:0] ERR_CURR_LIMIT = 8'h2b;
    localparam logic [7:0] ERR_OVP_LIMIT = 8'h2c;
    localparam logic [7:0] ERR_DELAY_LIMIT = 8'h2d;
    localparam logic [7:0] ERR_MASK_LIMIT = 8'h2e;

    // ************************************************************
    // standard event status bits, error classes
    // ************************************************************
    localparam int ESR_QUERY = 2;
    localparam int ESR_DEVICE = 3;
    localparam int ESR_EXEC = 4;
    localparam int ESR_CMD = 5;

    // one-hot error classes
    typedef enum logic [3:0] {
        SER_CLS_CMD = 4'h1,
        SER_CLS_EXEC = 4'h2,
        SER_CLS_DEV = 4'h4,
        SER_CLS_QUERY = 4'h8
    } ser_class_type;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic volt_regulating;
        logic pos_current_regulating;
        logic neg_current_regulating;
        logic overvoltage_trip;
        logic overtemp_trip;
        logic overcurrent_trip;
        logic remote_inhibit_flag;
        logic fast_speed_flag;
        logic normal_speed_flag;
    } ser_cond_type;

    typedef struct packed {
        logic hdr_expected;
        logic hdr_unknown;
        logic num_expected;
        logic num_syntax;
        logic num_range;
        logic missing_comma;
        logic missing_term;
    } ser_parse_err_type;

    typedef struct packed {
        logic generic;
        logic volt;
        logic curr;
        logic ovp;
        logic delay;
        logic mask;
    } ser_limit_err_type;

endpackage

/* dv/ser_status_properties.sv */
// checker for the status and error reporting block
`timescale 1ns/10ps
module ser_status_properties (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // watched inputs
    input wire ser_pkg::ser_cond_type cond_in,
    input wire logic busy_in,
    input wire ser_pkg::ser_parse_err_type parse_err_in,
    input wire ser_pkg::ser_limit_err_type limit_err_in,
    input wire logic fault_mask_command_in,
    input wire logic [11:0] fault_mask_value_in,
    input wire logic err_query_in,
    input wire logic fault_query_in,
    input wire logic serial_poll_in,
    input wire logic clear_command_in,
    // watched outputs
    input wire logic [11:0] operating_status_out,
    input wire logic [11:0] fault_latch_out,
    input wire logic [11:0] fault_enable_mask_out,
    input wire logic [7:0] poll_summary_byte_out,
    input wire logic [7:0] error_code_out,
    input wire logic error_valid_out,
    input wire logic [7:0] event_status_out
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_unused_bit: assert property (!operating_status_out[5] && !fault_latch_out[5])
        else $error("unused status bit set");
    chk_poll_spare: assert property ((poll_summary_byte_out & 8'h8c) == 8'h00)
        else $error("spare poll bit set");
    chk_err_copy: assert property (
        poll_summary_byte_out[5] == operating_status_out[7]
        && error_valid_out == operating_status_out[7])
        else $error("poll error bit differs from status");
    chk_fault_sum: assert property (
        poll_summary_byte_out[0] == (fault_latch_out != 12'h000))
        else $error("fault summary wrong");
    chk_ready_busy: assert property (1'b1 |=> poll_summary_byte_out[4] == !$past(busy_in))
        else $error("ready bit does not follow busy");
    chk_err_hold: assert property (
        operating_status_out[7] && !err_query_in |=> operating_status_out[7])
        else $error("error bit dropped without query");
    chk_parse_code: assert property (
        parse_err_in.hdr_expected |=> error_code_out == 8'h0a && event_status_out[3])
        else $error("header error not reported");
    // a poll in the cycle after a new fault may lose to the set
    chk_poll_clear: assert property (
        serial_poll_in && !fault_query_in && poll_summary_byte_out[0]
        && $past(poll_summary_byte_out[0]) |=> !poll_summary_byte_out[6])
        else $error("request bit kept after poll");
    chk_powerup_clear: assert property (
        clear_command_in || !poll_summary_byte_out[1] |=> !poll_summary_byte_out[1])
        else $error("powerup bit wrong");
    chk_mask_write: assert property (
        fault_mask_command_in && !limit_err_in.mask
        |=> (fault_enable_mask_out & ser_pkg::STAT_VALID_MASK)
        == ($past(fault_mask_value_in) & ser_pkg::STAT_VALID_MASK))
        else $error("mask write lost");
    chk_trip_delay: assert property (cond_in.overvoltage_trip [*5] |-> operating_status_out[3])
        else $error("trip not shown in status");

    cov_request: cover property ($rose(poll_summary_byte_out[6]));
    cov_error: cover property ($rose(error_valid_out));
    cov_fault_read: cover property (fault_query_in && fault_latch_out != 12'h000);
endmodule

bind ser_status_report ser_status_properties i_chk (
    .clk_in, .resetn_in, .cond_in, .busy_in, .parse_err_in, .limit_err_in,
    .fault_mask_command_in, .fault_mask_value_in, .err_query_in, .fault_query_in,
    .serial_poll_in, .clear_command_in, .operating_status_out, .fault_latch_out,
    .fault_enable_mask_out, .poll_summary_byte_out, .error_code_out, .error_valid_out,
    .event_status_out
);

/* dv/ser_ctrl_model.sv */
// model of the bus controller: queries, polls, clears and talk strobes
`timescale 1ns/10ps
module ser_ctrl_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // requests from the bench
    input wire logic [5:0] req_in,
    input wire logic pend_in,
    input wire logic slow_in,
    // strobes to the block
    output logic [5:0] pulse_out,
    output logic pending_out
);
    // ************************************************************
    // strobe timing
    // ************************************************************
    logic [5:0] held_reg;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            held_reg <= 6'h00;
            pulse_out <= 6'h00;
            pending_out <= 1'b0;
        end
        else
        begin
            // slow controller answers one cycle late
            held_reg <= req_in;
            pulse_out <= slow_in ? held_reg : req_in;
            pending_out <= pend_in;
        end
    end
endmodule

/* dv/tb.sv */
// self-checking bench for the status and error reporting block
`timescale 1ns/10ps
module tb;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    ser_pkg::ser_cond_type cond_in = '0;
    ser_pkg::ser_parse_err_type parse_err_in = '0;
    ser_pkg::ser_limit_err_type limit_err_in = '0;
    logic busy_in = 1'b0;
    logic srq_cmd_in = 1'b0;
    logic srq_cmd_value_in = 1'b0;
    logic fault_mask_command_in = 1'b0;
    logic [11:0] fault_mask_value_in = 12'h000;
    logic [3:0] misc = 4'h0;
    logic [5:0] req = 6'h00;
    logic pend = 1'b0;
    logic slow = 1'b0;
    logic [5:0] pulse;
    logic pending;
    logic [11:0] st, ast, flt, msk, e, m;
    logic [7:0] poll, code, esr, ec;
    logic ev, err_seen = 1'b0;
    logic [31:0] lfsr = 32'h66c1;
    logic [7:0] exp_q[$];
    logic [7:0] codes [18] = '{8'h0a, 8'h0b, 8'h14, 8'h15, 8'h16, 8'h1e, 8'h1f, 8'h29, 8'h2a,
        8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h01, 8'h02, 8'h04, 8'h05, 8'h08};
    int smap [9] = '{11, 10, 8, 6, 4, 3, 9, 1, 0};
    int fail_count = 0;
    int samples_checked = 0;
    int n;

    always #5 clk_in = ~clk_in;

    ser_ctrl_model i_ctrl (.clk_in, .resetn_in, .req_in(req), .pend_in(pend), .slow_in(slow),
        .pulse_out(pulse), .pending_out(pending));

    ser_status_report i_dut (
        .clk_in, .resetn_in, .cond_in, .busy_in, .parse_err_in, .limit_err_in,
        .nv_save_fail_in(misc[3]), .pon_cmd_in(misc[2]), .pon_cmd_value_in(1'b1),
        .relay_pon_cmd_in(misc[1]), .relay_cmd_in(misc[0]),
        .talk_addressed_in(pulse[5]), .query_pending_in(pending),
        .srq_cmd_in, .srq_cmd_value_in, .clear_command_in(pulse[4]),
        .fault_mask_command_in, .fault_mask_value_in,
        .err_query_in(pulse[0]), .fault_query_in(pulse[1]),
        .astatus_query_in(pulse[2]), .serial_poll_in(pulse[3]),
        .operating_status_out(st), .accumulated_status_out(ast), .fault_latch_out(flt),
        .fault_enable_mask_out(msk), .poll_summary_byte_out(poll), .error_code_out(code),
        .error_valid_out(ev), .event_status_out(esr)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input string name, input logic [11:0] x, input logic [11:0] y);
        samples_checked++;
        if (x !== y)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, x, y);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask

    // controller strobe, then time for the slow path to land
    task automatic ctrl(input logic [5:0] v);
        @(posedge clk_in);
        req <= v;
        @(posedge clk_in);
        req <= 6'h00;
        tick(3);
    endtask

    task automatic raise_err(input int k);
        @(posedge clk_in);
        if (k < 7)
            parse_err_in <= 7'h40 >> k;
        else if (k < 13)
            limit_err_in <= 6'h20 >> (k - 7);
        else if (k < 17)
            misc <= 4'h8 >> (k - 13);
        else
            req <= 6'h20;
        @(posedge clk_in);
        parse_err_in <= '0;
        limit_err_in <= '0;
        misc <= 4'h0;
        req <= 6'h00;
    endtask

    // error reports are compared in order as they appear
    always @(negedge clk_in)
    begin
        if (ev === 1'b1 && err_seen !== 1'b1)
        begin
            ec = exp_q.pop_front();
            check("error code", {4'h0, ec}, {4'h0, code});
            check("event class", 12'h008, {4'h0, esr & 8'h3c});
        end
        err_seen = ev;
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        repeat (5) @(posedge clk_in);
        check("poll at reset", 12'h012, {4'h0, poll});
        check("mask at reset", 12'h000, msk);
        resetn_in <= 1'b1;
        $display("reset test done");
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk_in);
            cond_in <= 9'h001 << i;
            tick(5);
            e = (12'h001 << smap[i]) | (i < 6 ? 12'h004 : 12'h000);
            check("stat lo", e & 12'h01f, st & 12'h01f);
            check("stat mid", e & 12'h0e0, st & 12'h0e0);
            check("stat hi", e & 12'hf00, st & 12'hf00);
        end
        @(posedge clk_in);
        cond_in <= '0;
        tick(5);
        check("astatus", 12'hf5f, ast);
        ctrl(6'h04);
        check("astatus reload", 12'h004, ast);
        $display("status test done");
        raise_err(14);
        pend <= 1'b1;
        ctrl(6'h20);
        check("talk with query", 12'h000, {11'h0, ev});
        pend <= 1'b0;
        for (int k = 0; k < 18; k++)
        begin
            exp_q.push_back(codes[k]);
            raise_err(k);
            tick(2);
            check("error bits", 12'h003, {10'h0, st[7], poll[5]});
            ctrl(6'h01);
            check("error cleared", 12'h000, {3'h0, st[7], code});
        end
        ctrl(6'h10);
        check("powerup cleared", 12'h000, {10'h0, poll[1], esr[3]});
        @(posedge clk_in);
        busy_in <= 1'b1;
        tick(2);
        check("ready while busy", 12'h000, {11'h0, poll[4]});
        @(posedge clk_in);
        busy_in <= 1'b0;
        tick(2);
        check("ready when done", 12'h001, {11'h0, poll[4]});
        $display("error test done");
        lfsr = lfsr_next(lfsr);
        m = (lfsr[11:0] & 12'hfcb) | 12'h008;
        @(posedge clk_in);
        fault_mask_command_in <= 1'b1;
        fault_mask_value_in <= m;
        srq_cmd_in <= 1'b1;
        srq_cmd_value_in <= 1'b1;
        @(posedge clk_in);
        fault_mask_command_in <= 1'b0;
        srq_cmd_in <= 1'b0;
        cond_in <= 9'h030;
        n = 0;
        while (flt[3] !== 1'b1 && n < 8)
        begin
            tick(1);
            n++;
        end
        if (n == 8)
        begin
            fail_count++;
            report_and_stop();
        end
        tick(2);
        check("mask", m, msk);
        check("fault latch", 12'h008, flt);
        check("request", 12'h003, {10'h0, poll[6], poll[0]});
        slow <= 1'b1;
        ctrl(6'h08);
        slow <= 1'b0;
        check("after poll", 12'h001, {10'h0, poll[6], poll[0]});
        @(posedge clk_in);
        cond_in <= '0;
        srq_cmd_in <= 1'b1;
        srq_cmd_value_in <= 1'b0;
        @(posedge clk_in);
        srq_cmd_in <= 1'b0;
        tick(4);
        ctrl(6'h02);
        check("fault query", 12'h000, {flt[11:1], poll[0]});
        @(posedge clk_in);
        cond_in <= 9'h020;
        tick(6);
        check("no request when off", 12'h001, {10'h0, poll[6], poll[0]});
        $display("fault test done");
        report_and_stop();
    end
endmodule
